// ---- hw/etu_top.sv ----
// Event transfer unit: interrupt activated descriptor based memory mover.
`timescale 1ns/10ps
module etu_top #(
  parameter int unsigned NVEC = 256
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // Activation from the interrupt controller
  input  wire logic               act_req,
  input  wire logic [7:0]         act_vec,
  input  wire logic [NVEC-1:0]    per_vector_activation_enable,
  output logic                    act_ack,
  // Configuration
  input  wire logic [31:0]        vector_table_base,
  input  wire logic               address_format_select,
  input  wire logic               transfer_unit_run,
  input  wire logic               module_stop,
  input  wire logic               big_endian,
  // System bus
  output etu_pkg::etu_bus_req_t   bus_o,
  input  wire logic               bus_ready,
  input  wire logic [31:0]        bus_rdata,
  // Status
  output logic                    active_q,
  output logic [7:0]              active_vec_q,
  output logic                    stop_ack
);

  // ==========================================================================
  // Reset synchroniser
  // ==========================================================================
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] swap32(input logic [31:0] w, input logic be);
    swap32 = be ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction

  function automatic logic [31:0] ext24(input logic [31:0] a);
    ext24 = {{8{a[23]}}, a[23:0]};
  endfunction

  // Walks an address back over k units so a repeat area needs no start register.
  function automatic logic [31:0] rewind(input logic [31:0] a, input logic [1:0] inc,
                                         input logic [1:0] sz, input logic [7:0] k);
    logic [31:0] d;
    d = {24'h00_0000, k} << sz;
    case (inc)
      2'b10:   rewind = a - d;
      2'b11:   rewind = a + d;
      default: rewind = a;
    endcase
  endfunction

  function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] inc,
                                       input logic [1:0] sz);
    logic [31:0] n;
    n = (sz == etu_pkg::SZ_LONG) ? 32'h0000_0004 :
        (sz == etu_pkg::SZ_WORD) ? 32'h0000_0002 : 32'h0000_0001;
    case (inc)
      2'b10:   step = a + n;
      2'b11:   step = a - n;
      default: step = a;
    endcase
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  etu_pkg::etu_state_t state_q;
  etu_pkg::etu_desc_t  desc_q;
  logic [31:0] desc_addr_q, data_q, blk_src_q, blk_dst_q;
  logic [2:0]  idx_q;
  logic [15:0] blk_q;
  logic        short_q, last_q;

  wire logic run_ok  = transfer_unit_run && !module_stop;
  wire logic [31:0] vt_base = vector_table_base & etu_pkg::VT_BASE_MASK;
  // The ignored low bits must not push a legal base out of range.
  wire logic base_ok = (vt_base <= etu_pkg::VT_LOW_TOP) ||
                       (vt_base >= etu_pkg::VT_HIGH_BOTTOM);
  wire logic start = (state_q == etu_pkg::ST_IDLE) && act_req && run_ok && base_ok &&
                     per_vector_activation_enable[act_vec];
  wire logic [2:0] nwords = address_format_select ?
                            3'(etu_pkg::SHORT_WORDS) : 3'(etu_pkg::FULL_WORDS);
  wire logic [2:0] lastw = short_q ? 3'(etu_pkg::SHORT_WORDS - 1) :
                                     3'(etu_pkg::FULL_WORDS - 1);
  wire logic [31:0] rd = swap32(bus_rdata, big_endian);
  // Word to present next, so an answered word is never offered twice.
  wire logic [2:0] wb_idx = idx_q + 3'(bus_ready);

  assign act_ack  = start;
  assign stop_ack = module_stop && (state_q == etu_pkg::ST_IDLE);

  // Packed words for write-back, same layout as fetched.
  logic [31:0] wb_word;
  always_comb begin
    wb_word = 32'h0000_0000;
    case (wb_idx)
      3'd0: wb_word = {desc_q.mode, desc_q.size, desc_q.rpt_dst, desc_q.sinc,
                       desc_q.dinc, 15'h0000, short_q ? desc_q.cnt_a[7:0] : 8'h00};
      3'd1: wb_word = short_q ? {8'h00, desc_q.src[23:0]} : desc_q.src;
      3'd2: wb_word = short_q ? {8'h00, desc_q.dst[23:0]} : desc_q.dst;
      default: wb_word = {desc_q.cnt_a, desc_q.cnt_b};
    endcase
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q      <= etu_pkg::ST_IDLE;
      idx_q        <= 3'd0;
      short_q      <= 1'b0;
      desc_addr_q  <= 32'h0000_0000;
      active_vec_q <= 8'h00;
    end else begin
      case (state_q)
        etu_pkg::ST_IDLE: begin
          if (start) begin
            active_vec_q <= act_vec;
            short_q      <= address_format_select;
            state_q      <= etu_pkg::ST_VEC;
          end
        end
        etu_pkg::ST_VEC: begin
          if (bus_ready) begin
            desc_addr_q <= rd;
            idx_q       <= 3'd0;
            state_q     <= etu_pkg::ST_DESC;
          end
        end
        etu_pkg::ST_DESC: begin
          if (bus_ready) begin
            idx_q <= idx_q + 3'd1;
            if (idx_q == lastw) begin
              state_q <= etu_pkg::ST_READ;
            end
          end
        end
        etu_pkg::ST_READ: if (bus_ready) state_q <= etu_pkg::ST_WRITE;
        etu_pkg::ST_WRITE: if (bus_ready) state_q <= etu_pkg::ST_UPDATE;
        etu_pkg::ST_UPDATE: begin
          idx_q   <= 3'd0;
          state_q <= last_q ? etu_pkg::ST_WBACK : etu_pkg::ST_READ;
        end
        etu_pkg::ST_WBACK: begin
          if (bus_ready) begin
            idx_q <= idx_q + 3'd1;
            if (idx_q == lastw) state_q <= etu_pkg::ST_DONE;
          end
        end
        etu_pkg::ST_DONE: state_q <= etu_pkg::ST_IDLE;
        default: state_q <= etu_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Descriptor and data path
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      desc_q    <= '0;
      data_q    <= 32'h0000_0000;
      blk_q     <= 16'h0000;
      blk_src_q <= 32'h0000_0000;
      blk_dst_q <= 32'h0000_0000;
      last_q    <= 1'b0;
    end else begin
      if (state_q == etu_pkg::ST_DESC && bus_ready) begin
        case (idx_q)
          3'd0: begin
            desc_q.mode    <= rd[31:30];
            desc_q.size    <= rd[29:28];
            desc_q.rpt_dst <= rd[27];
            desc_q.sinc    <= rd[26:25];
            desc_q.dinc    <= rd[24:23];
            if (short_q) {desc_q.cnt_a, desc_q.cnt_b} <= {8'h00, rd[7:0], 16'h0000};
          end
          3'd1: desc_q.src <= short_q ? ext24(rd) : rd;
          3'd2: desc_q.dst <= short_q ? ext24(rd) : rd;
          default: {desc_q.cnt_a, desc_q.cnt_b} <= rd;
        endcase
      end
      if (state_q == etu_pkg::ST_READ) begin
        blk_src_q <= desc_q.src;
        blk_dst_q <= desc_q.dst;
        if (blk_q == 16'h0000) blk_q <= desc_q.cnt_b;
        if (bus_ready) data_q <= bus_rdata;
      end
      if (state_q == etu_pkg::ST_UPDATE) begin
        desc_q.src <= step(desc_q.src, desc_q.sinc, desc_q.size);
        desc_q.dst <= step(desc_q.dst, desc_q.dinc, desc_q.size);
        last_q     <= 1'b0;
        case (desc_q.mode)
          etu_pkg::MD_REPEAT: begin
            // Count in low byte; zero means 256 and the high byte reloads it.
            if (desc_q.cnt_a[7:0] == 8'h01) begin
              desc_q.cnt_a[7:0] <= desc_q.cnt_a[15:8];
              if (desc_q.rpt_dst) desc_q.dst <= rewind(desc_q.dst, desc_q.dinc, desc_q.size,
                                                       desc_q.cnt_a[15:8] - 8'h01);
              else desc_q.src <= rewind(desc_q.src, desc_q.sinc, desc_q.size,
                                        desc_q.cnt_a[15:8] - 8'h01);
            end else begin
              desc_q.cnt_a[7:0] <= desc_q.cnt_a[7:0] - 8'h01;
            end
          end
          etu_pkg::MD_BLOCK: begin
            blk_q <= blk_q - 16'h0001;
            last_q <= (blk_q == 16'h0001);
            if (blk_q == 16'h0001) desc_q.cnt_b <= desc_q.cnt_b - 16'h0001;
          end
          default: desc_q.cnt_a <= desc_q.cnt_a - 16'h0001;
        endcase
        if (desc_q.mode != etu_pkg::MD_BLOCK) last_q <= 1'b0;
      end
      if (state_q == etu_pkg::ST_WRITE && bus_ready && desc_q.mode != etu_pkg::MD_BLOCK)
        last_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Bus drive and status
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bus_o    <= '0;
      active_q <= 1'b0;
    end else begin
      active_q    <= (state_q != etu_pkg::ST_IDLE) || start;
      bus_o.req   <= 1'b0;
      bus_o.we    <= 1'b0;
      bus_o.size  <= etu_pkg::SZ_LONG;
      bus_o.addr  <= 32'h0000_0000;
      bus_o.wdata <= 32'h0000_0000;
      case (state_q)
        etu_pkg::ST_VEC: begin
          bus_o.req  <= !bus_ready;
          bus_o.addr <= vt_base + {22'h0, active_vec_q, 2'b00};
        end
        etu_pkg::ST_DESC: begin
          bus_o.req  <= !(bus_ready && idx_q == lastw);
          bus_o.addr <= desc_addr_q + {27'h0, idx_q + 3'(bus_ready), 2'b00};
        end
        etu_pkg::ST_READ: begin
          bus_o.req  <= !bus_ready;
          bus_o.size <= desc_q.size;
          bus_o.addr <= desc_q.src;
        end
        etu_pkg::ST_WRITE: begin
          bus_o.req   <= !bus_ready;
          bus_o.we    <= 1'b1;
          bus_o.size  <= desc_q.size;
          bus_o.addr  <= desc_q.dst;
          bus_o.wdata <= data_q;
        end
        etu_pkg::ST_WBACK: begin
          bus_o.req   <= !(bus_ready && idx_q == lastw);
          bus_o.we    <= 1'b1;
          bus_o.addr  <= desc_addr_q + {27'h0, wb_idx, 2'b00};
          bus_o.wdata <= swap32(wb_word, big_endian);
        end
        default: bus_o.req <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  gated_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    act_ack |-> per_vector_activation_enable[act_vec] && transfer_unit_run)
    else $error("activation taken for disabled vector");
  stop_blocks_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    module_stop |-> !act_ack) else $error("activation while stopped");
  vec_fetch_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    act_ack |=> ##1 bus_o.addr == vt_base + {22'h0, $past(act_vec, 2), 2'b00})
    else $error("wrong vector entry address");
  wback_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    state_q == etu_pkg::ST_DONE |-> $past(state_q) == etu_pkg::ST_WBACK)
    else $error("activation ended without write-back");
  short_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    state_q == etu_pkg::ST_DESC && short_q |-> idx_q < 3'd3)
    else $error("short descriptor fetch too long");
  full_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    $rose(state_q == etu_pkg::ST_READ) && $past(state_q) == etu_pkg::ST_DESC && !short_q
      |-> $past(idx_q) == 3'd3)
    else $error("full descriptor fetch not four words");
  base_align_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    state_q == etu_pkg::ST_VEC && bus_o.req |->
      bus_o.addr[31:10] == vector_table_base[31:10])
    else $error("vector base not 1 KB aligned");
  short_ext_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    state_q == etu_pkg::ST_READ && short_q |->
      desc_q.src <= 32'h00FF_FFFF ? desc_q.src < 32'h0080_0000 :
      desc_q.src >= etu_pkg::SHORT_HIGH_BOTTOM)
    else $error("short address outside reachable space");
  run_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q)
    state_q == etu_pkg::ST_IDLE && act_req && transfer_unit_run && !module_stop && base_ok &&
      per_vector_activation_enable[act_vec] |-> act_ack)
    else $error("enabled activation refused");
  act_c: cover property (@(posedge sys_clk) act_ack);
  rpt_c: cover property (@(posedge sys_clk) state_q == etu_pkg::ST_UPDATE &&
                         desc_q.mode == etu_pkg::MD_REPEAT);
  blk_c: cover property (@(posedge sys_clk) state_q == etu_pkg::ST_UPDATE &&
                         desc_q.mode == etu_pkg::MD_BLOCK);
  done_c: cover property (@(posedge sys_clk) state_q == etu_pkg::ST_DONE && short_q);

endmodule // etu_top

// ---- hw/etu_pkg.sv ----
// Package for the event transfer unit: constants, states and carrier types.
package etu_pkg;

  // ==========================================================================
  // Descriptor layout and sizes
  // ==========================================================================
  localparam int unsigned FULL_WORDS        = 4;
  localparam int unsigned SHORT_WORDS       = 3;
  localparam int unsigned NORMAL_MAX        = 65536;
  localparam int unsigned REPEAT_MAX        = 256;
  localparam int unsigned VECTORS           = 256;
  localparam logic [31:0] VT_BASE_MASK      = 32'hFFFF_FC00;
  localparam logic [31:0] VT_LOW_TOP        = 32'h07FF_FC00;
  localparam logic [31:0] VT_HIGH_BOTTOM    = 32'hF800_0000;
  localparam logic [31:0] SHORT_HIGH_BOTTOM = 32'hFF80_0000;
  localparam int unsigned SHORT_ADDR_BITS   = 24;

  // Reset values.
  localparam logic        RUN_RESET         = 1'b1;
  localparam logic        STOP_RESET        = 1'b0;

  // ==========================================================================
  // Encodings
  // ==========================================================================
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } etu_size_t;

  typedef enum logic [1:0] {
    MD_NORMAL = 2'b00,
    MD_REPEAT = 2'b01,
    MD_BLOCK  = 2'b10
  } etu_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_VEC    = 4'b0001,
    ST_DESC   = 4'b0010,
    ST_READ   = 4'b0011,
    ST_WRITE  = 4'b0100,
    ST_UPDATE = 4'b0101,
    ST_WBACK  = 4'b0110,
    ST_DONE   = 4'b0111
  } etu_state_t;

  // Bus request carried to system memory.
  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } etu_bus_req_t;

  // Decoded descriptor: word 0 mode/size/flags, then addresses and count.
  typedef struct packed {
    logic [1:0]  mode;
    logic [1:0]  size;
    logic        rpt_dst;
    logic [1:0]  sinc;
    logic [1:0]  dinc;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
  } etu_desc_t;

endpackage : etu_pkg

// ---- tb/etu_mem_model.sv ----
// Behavioural system memory that answers the transfer unit's bus.
`timescale 1ns/10ps
module etu_mem_model (
  // Clock
  input  wire logic                  sys_clk,
  // System bus
  input  wire etu_pkg::etu_bus_req_t bus_o,
  output logic                       bus_ready,
  output logic [31:0]                bus_rdata
);
  // ==========================================================
  // Storage and access log
  // ==========================================================
  logic [31:0] mem [logic [29:0]];
  logic [31:0] rd_q [$];
  logic [31:0] wr_q [$];
  logic [1:0]  sz_q [$];
  int          lat = 0;
  bit          slow = 0;

  initial begin
    bus_ready = 1'b0;
    bus_rdata = 32'h0000_0000;
  end

  // ==========================================================
  // Access handling
  // ==========================================================
  // Read data toggles outside ready, so a stale word never passes for an answer.
  always @(posedge sys_clk) begin
    bus_ready <= 1'b0;
    bus_rdata <= ~bus_rdata;
    if (bus_o.req && !bus_ready) begin
      if (lat > 0) begin
        lat <= lat - 1;
      end else begin
        bus_ready <= 1'b1;
        lat       <= slow ? $urandom_range(2, 0) : 0;
        sz_q.push_back(bus_o.size);
        if (bus_o.we) begin
          mem[bus_o.addr[31:2]] = bus_o.wdata;
          wr_q.push_back(bus_o.addr);
        end else begin
          bus_rdata <= mem.exists(bus_o.addr[31:2]) ? mem[bus_o.addr[31:2]] : 32'hA5A5_A5A5;
          rd_q.push_back(bus_o.addr);
        end
      end
    end
  end
endmodule // etu_mem_model

// ---- tb/testbench.sv ----
// Self-checking testbench for the event transfer unit.
`timescale 1ns/10ps
module testbench;
  // ==========================================================
  // Signals
  // ==========================================================
  logic                  sys_clk;
  logic                  nrst;
  logic                  act_req;
  logic [7:0]            act_vec;
  logic [255:0]          pvae;
  logic                  act_ack;
  logic [31:0]           vector_table_base;
  logic                  address_format_select;
  logic                  transfer_unit_run;
  logic                  module_stop;
  logic                  big_endian;
  etu_pkg::etu_bus_req_t bus_o;
  logic                  bus_ready;
  logic [31:0]           bus_rdata;
  logic                  active_q;
  logic [7:0]            active_vec_q;
  logic                  stop_ack;
  int                    bad_count = 0, checked = 0, cyc = 0, k, n, fmt, be, s;
  logic [31:0]           base, desc, src, dst, data, w, step, mask;
  logic [15:0]           c;

  etu_top #(.NVEC(256)) i_dut (
    .sys_clk, .nrst, .act_req, .act_vec, .per_vector_activation_enable(pvae), .act_ack,
    .vector_table_base, .address_format_select, .transfer_unit_run, .module_stop,
    .big_endian, .bus_o, .bus_ready, .bus_rdata, .active_q, .active_vec_q, .stop_ack
  );
  etu_mem_model i_mem (.sys_clk, .bus_o, .bus_ready, .bus_rdata);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      $display("CHECK FAILED timeout expected %0d seen %0d", 20000, cyc);
      finish_test();
    end
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic finish_test();
    $display("TB: %0d checks, %0d mismatches", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] swap(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  // Descriptor words follow the byte order setting; moved data words do not.
  task automatic put(input logic [31:0] a, input logic [31:0] v);
    i_mem.mem[a[31:2]] = be ? swap(v) : v;
  endtask

  function automatic logic [31:0] get(input logic [31:0] a);
    return be ? swap(i_mem.mem[a[31:2]]) : i_mem.mem[a[31:2]];
  endfunction

  task automatic load(input logic [1:0] m);
    put(desc, {m, s[1:0], 1'b0, 4'b1010, 15'h0000, fmt ? c[7:0] : 8'h00});
    put(desc + 4, fmt ? {8'h00, src[23:0]} : src);
    put(desc + 8, fmt ? {8'h00, dst[23:0]} : dst);
    put(desc + 12, {c, 16'h0001});
  endtask

  // The descriptor address reads the same in both byte orders, so the table
  // entry is right whether or not it is swapped.
  task automatic go(input logic [7:0] v);
    act_vec           <= v;
    pvae              <= 256'h1 << v;
    vector_table_base <= base;
    w = (base & etu_pkg::VT_BASE_MASK) + {22'h0, v, 2'b00};
    i_mem.mem[w[31:2]] = desc;
    @(posedge sys_clk);
    i_mem.rd_q.delete();
    i_mem.wr_q.delete();
    i_mem.sz_q.delete();
    act_req <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (act_ack !== 1'b1 && k < 20);
    act_req <= 1'b0;
    chk("act_ack", 1, act_ack);
    repeat (2) @(posedge sys_clk);
    chk("active_vec_q", v, active_vec_q);
    k = 0;
    while (active_q !== 1'b0 && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
    chk("active_q", 0, active_q);
  endtask

  task automatic refuse(input int i);
    k = 0;
    act_req <= 1'b1;
    repeat (8) begin
      @(posedge sys_clk);
      if (act_ack !== 1'b0) k++;
    end
    act_req <= 1'b0;
    chk("refused act_ack", 0, k);
    if (i == 2) chk("stop_ack", 1, stop_ack);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    nrst = 1'b0;
    act_req = 1'b0;
    act_vec = 8'h00;
    pvae = '0;
    vector_table_base = 32'h0000_0000;
    address_format_select = 1'b0;
    transfer_unit_run = 1'b1;
    module_stop = 1'b0;
    big_endian = 1'b0;
    be = 0;
    k = $urandom(32'h0829_b2e4);
    desc = 32'h0010_1000;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("stop_ack after reset", 0, stop_ack);
    for (int i = 0; i < 5; i++) begin
      base = (i == 3) ? 32'h0800_0000 : (i == 4) ? 32'hF7FF_FC00 : 32'h0000_0000;
      vector_table_base <= base;
      pvae              <= (i == 0) ? '0 : '1;
      transfer_unit_run <= (i != 1);
      module_stop       <= (i == 2);
      @(posedge sys_clk);
      refuse(i);
      $display("TB: refusal case %0d done", i);
    end
    transfer_unit_run <= 1'b1;
    module_stop       <= 1'b0;
    for (be = 0; be < 2; be++) begin
      for (fmt = 0; fmt < 2; fmt++) begin
        for (s = 0; s < 3; s++) begin
          big_endian            <= be[0];
          address_format_select <= fmt[0];
          i_mem.slow = be[0];
          base = s[0] ? 32'hF800_0000 | ($urandom & 32'h03FF_FFFF)
                      : etu_pkg::VT_LOW_TOP | ($urandom & 32'h0000_03FF);
          src  = fmt ? 32'hFF80_0000 | ($urandom & 32'h0007_FFFC)
                     : 32'h0020_0000 | ($urandom & 32'h000F_FFFC);
          dst  = 32'h0030_0000 | ($urandom & 32'h000F_FFFC);
          c    = 16'($urandom_range(255, 1));
          data = $urandom;
          step = 32'h1 << s;
          i_mem.mem[src[31:2]] = data;
          load(etu_pkg::MD_NORMAL);
          go(8'($urandom));
          n    = fmt ? 3 : 4;
          mask = fmt ? 32'h00FF_FFFF : 32'hFFFF_FFFF;
          chk("reads", n + 2, i_mem.rd_q.size());
          chk("writes", n + 1, i_mem.wr_q.size());
          chk("vector fetch", (base & etu_pkg::VT_BASE_MASK) + 4 * act_vec, i_mem.rd_q[0]);
          chk("last desc fetch", desc + 4 * (n - 1), i_mem.rd_q[n]);
          chk("source read", src, i_mem.rd_q[n + 1]);
          chk("dest write", dst, i_mem.wr_q[0]);
          chk("unit size", s, i_mem.sz_q[n + 1]);
          chk("wb source", (src + step) & mask, get(desc + 4) & mask);
          chk("wb dest", (dst + step) & mask, get(desc + 8) & mask);
          w = fmt ? get(desc) & 32'h0000_00FF : get(desc + 12) >> 16;
          chk("wb count", c - 1, w);
          if (s == 2) chk("data", data, i_mem.mem[dst[31:2]]);
          $display("TB: normal be=%0d short=%0d size=%0d done", be, fmt, s);
        end
      end
    end
    be = 0;
    fmt = 0;
    s = 2;
    big_endian            <= 1'b0;
    address_format_select <= 1'b0;
    base = 32'h0000_0400;
    c    = 16'h0303;
    load(etu_pkg::MD_REPEAT);
    for (int r = 0; r < 3; r++) go(8'h7F);
    chk("repeat source", src, get(desc + 4));
    chk("repeat dest", dst + 12, get(desc + 8));
    chk("repeat count", 16'h0303, get(desc + 12) >> 16);
    $display("TB: repeat test done");
    finish_test();
  end
endmodule // testbench
